// [pms_clock_monitor.sv]
/*
 external clock monitor: watches a synchronised activity toggle.
 assumes the toggle flips at least once per window while healthy.
*/
`timescale 1ns/1ns
module pms_clock_monitor #(
    parameter int window = pms_pkg::pms_fail_window
) (
    input wire logic clock,
    input wire logic sys_rst,
    input wire logic enable,
    input wire logic activity,
    output logic failed
);
    logic last;
    logic [7:0] idle_count;

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            failed <= 1'b0;
        end
        if (sys_rst || !enable) begin
            last <= 1'b0;
            idle_count <= 8'h00;
        end else begin
            last <= activity;
            if (activity != last) begin
                idle_count <= 8'h00;
            end else if (idle_count < 8'(window)) begin
                idle_count <= idle_count + 8'h01;
            end else begin
                failed <= 1'b1;
            end
        end
    end
endmodule : pms_clock_monitor

// [pms_far_side.sv]
/*
 far side model: external crystal and rc-requesting peripherals.
 assumes the supervisor grants the rc clock on a registered port.
*/
`timescale 1ns/1ns
module pms_far_side (
    input wire logic clock,
    input wire logic osc_run,
    input wire logic [2:0] want_rc,
    input wire logic [2:0] rc_clock_grant,
    output logic [2:0] rc_clock_request,
    output logic external_clock_activity
);
    // crystal toggle, unrelated in phase, still when stopped
    initial external_clock_activity = 1'b0;
    always #31 if (osc_run) external_clock_activity = ~external_clock_activity;
    // request held until the clock has been served at least once
    initial rc_clock_request = 3'h0;
    always @(posedge clock) begin
        rc_clock_request <= want_rc | (rc_clock_request & ~rc_clock_grant);
    end
endmodule : pms_far_side

// [pms_pkg.sv]
/*
 power mode supervisor package: states, clock choices, counts.
 assumes nothing beyond a systemverilog compiler.
*/
// Behaviour
// - supervisors always on; valid operation above 2 V.
// - device held in reset while supply below threshold.
// - supervisor watches main and analog supply; analog part can be off.
// - detector interrupt on fall below, rise above, or both.
// - detector inactive until software enables it.
// - regulator on after reset; main in run; low power in stop.
// - standby: regulator off, output high impedance, core unpowered.
// - sleep halts only the processor; interrupt or event wakes it.
// - stop keeps contents; core clocks, pll, rc, crystal stopped.
// - stop ends on any wakeup line, 16 external and peripherals.
// - rc request in low-power stop restores main mode first.
// - standby ends on reset pin, watchdog, wakeup pin rise, rtc.
// - standby keeps only rtc-domain and standby registers.
// - rtc, watchdog and their clocks run in stop and standby.
// - io rail low disables every io on that rail.
// - io rail comparator drives wakeup line 31.
// - any reset selects the 8 MHz internal rc clock.
// - external clock monitored; on failure back to rc, irq if enabled (monitored here only while it is the direct cpu source, not via the pll).
package pms_pkg;
    typedef enum {
        pms_run,
        pms_sleep,
        pms_stop_enter,
        pms_stop,
        pms_stop_exit,
        pms_standby
    } pms_state_t;

    typedef enum logic [1:0] {
        pms_clk_rc,
        pms_clk_ext,
        pms_clk_pll
    } pms_clk_t;

    localparam int pms_io_rail_line = 31;
    localparam int pms_pvd_line = 16;
    localparam int pms_reg_settle_cycles = 25;
    localparam int pms_fail_window = 8;
    localparam logic [1:0] pms_pvd_mode_fall = 2'h1;
    localparam logic [1:0] pms_pvd_mode_rise = 2'h2;
endpackage : pms_pkg

// [pms_supervisor.sv]
/*
 power mode supervisor: supply supervision, regulator, low-power modes,
 wake sources, rc grants and clock selection with failure fallback.
 assumes analog comparators arrive as asynchronous level inputs and that
 processor requests, wakeup lines and peripheral requests share the clock.
*/
`timescale 1ns/1ns
module pms_supervisor #(
    parameter int settle_cycles = pms_pkg::pms_reg_settle_cycles,
    parameter int fail_window = pms_pkg::pms_fail_window
) (
    input wire logic clock,
    input wire logic sys_rst,
    input wire logic main_supply_ok,
    input wire logic analog_supply_ok,
    input wire logic analog_monitor_disable,
    input wire logic detector_above_level,
    input wire logic detector_enable,
    input wire logic [1:0] detector_mode,
    input wire logic detector_event_clear,
    input wire logic io_rail_ok,
    input wire logic sleep_request,
    input wire logic stop_request,
    input wire logic standby_request,
    input wire logic stop_low_power_select,
    input wire logic [15:0] external_lines,
    input wire logic [14:0] peripheral_lines,
    input wire logic [2:0] rc_clock_request,
    input wire logic external_reset_pin_n,
    input wire logic watchdog_reset,
    input wire logic wakeup_pin,
    input wire logic rtc_event,
    input wire logic interrupt_event,
    input wire logic [1:0] clock_select,
    input wire logic external_clock_activity,
    input wire logic clock_fail_irq_enable,
    output logic device_reset,
    output logic detector_irq,
    output logic regulator_on,
    output logic regulator_main_mode,
    output logic regulator_low_power_mode,
    output logic regulator_high_z,
    output logic core_power_on,
    output logic cpu_clock_enable,
    output logic core_clock_enable,
    output logic pll_enable,
    output logic internal_fast_rc_osc_enable,
    output logic external_crystal_osc_enable,
    output logic always_on_clocks_enable,
    output logic [2:0] rc_clock_grant,
    output logic io_rail_enable,
    output logic [31:0] wakeup_lines,
    output logic [1:0] cpu_clock_source,
    output logic clock_fail_irq,
    output logic [2:0] power_state
);
    pms_pkg::pms_state_t state;
    pms_pkg::pms_state_t next_state;
    logic main_ok_s;
    logic analog_ok_s;
    logic above_s;
    logic io_ok_s;
    logic reset_pin_n_s;
    logic wakeup_pin_s;
    logic ext_activity_s;
    logic above_last;
    logic wake_pin_last;
    logic detector_rise;
    logic detector_fall;
    logic supply_fault;
    logic standby_exit;
    logic any_wake_line;
    logic ext_failed;
    logic [7:0] settle_count;
    logic settled;
    logic [31:0] next_lines;

    ////////////////////////////////////////////////////////////////////////
    // asynchronous analog and pin inputs
    pms_sync #(
        .width(7)
    ) u_sync (
        .clock(clock),
        .sys_rst(sys_rst),
        .async_in({main_supply_ok, analog_supply_ok, detector_above_level,
            io_rail_ok, external_reset_pin_n, wakeup_pin,
            external_clock_activity}),
        .sync_out({main_ok_s, analog_ok_s, above_s, io_ok_s, reset_pin_n_s,
            wakeup_pin_s, ext_activity_s})
    );

    pms_clock_monitor #(
        .window(fail_window)
    ) u_monitor (
        .clock(clock),
        .sys_rst(sys_rst || device_reset),
        .enable(cpu_clock_source == pms_pkg::pms_clk_ext &&
            external_crystal_osc_enable),
        .activity(ext_activity_s),
        .failed(ext_failed)
    );

    ////////////////////////////////////////////////////////////////////////
    // supply supervision
    always_comb begin
        supply_fault = !main_ok_s;
        if (!analog_monitor_disable && !analog_ok_s) begin
            supply_fault = 1'b1;
        end
    end

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            device_reset <= 1'b1;
        end else begin
            device_reset <= supply_fault || !reset_pin_n_s ||
                watchdog_reset ||
                (state == pms_pkg::pms_standby && standby_exit);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // threshold voltage detector
    assign detector_rise = above_s && !above_last;
    assign detector_fall = !above_s && above_last;

    always_ff @(posedge clock) begin
        if (sys_rst || device_reset) begin
            above_last <= 1'b0;
            detector_irq <= 1'b0;
        end else begin
            above_last <= above_s;
            if (!detector_enable) begin
                detector_irq <= 1'b0;
            end else if ((detector_fall &&
                    (detector_mode & pms_pkg::pms_pvd_mode_fall) != 2'h0) ||
                    (detector_rise &&
                    (detector_mode & pms_pkg::pms_pvd_mode_rise) != 2'h0))
                    begin
                detector_irq <= 1'b1;
            end else if (detector_event_clear) begin
                detector_irq <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // wakeup lines
    always_comb begin
        next_lines = '0;
        next_lines[15:0] = external_lines;
        next_lines[pms_pkg::pms_pvd_line] = detector_enable && !above_s;
        next_lines[30:17] = peripheral_lines[13:0];
        next_lines[pms_pkg::pms_io_rail_line] = !io_ok_s;
    end

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            wakeup_lines <= '0;
            wake_pin_last <= 1'b0;
        end else begin
            wakeup_lines <= next_lines;
            wake_pin_last <= wakeup_pin_s;
        end
    end

    assign any_wake_line = |next_lines || peripheral_lines[14];
    assign standby_exit = !reset_pin_n_s || watchdog_reset || rtc_event ||
        (wakeup_pin_s && !wake_pin_last);

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            io_rail_enable <= 1'b0;
        end else begin
            io_rail_enable <= io_ok_s;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // mode sequencer
    always_comb begin
        next_state = state;
        case (state)
            pms_pkg::pms_run: begin
                if (standby_request) begin
                    next_state = pms_pkg::pms_standby;
                end else if (stop_request) begin
                    next_state = pms_pkg::pms_stop_enter;
                end else if (sleep_request) begin
                    next_state = pms_pkg::pms_sleep;
                end
            end
            pms_pkg::pms_sleep: begin
                if (interrupt_event || any_wake_line) begin
                    next_state = pms_pkg::pms_run;
                end
            end
            pms_pkg::pms_stop_enter: begin
                next_state = pms_pkg::pms_stop;
            end
            pms_pkg::pms_stop: begin
                if (any_wake_line) begin
                    next_state = pms_pkg::pms_stop_exit;
                end
            end
            pms_pkg::pms_stop_exit: begin
                if (settled) begin
                    next_state = pms_pkg::pms_run;
                end
            end
            pms_pkg::pms_standby: begin
                next_state = pms_pkg::pms_standby;
            end
            default: begin
                next_state = pms_pkg::pms_run;
            end
        endcase
    end

    always_ff @(posedge clock) begin
        if (sys_rst || device_reset) begin
            state <= pms_pkg::pms_run;
        end else begin
            state <= next_state;
        end
    end

    always_ff @(posedge clock) begin
        if (sys_rst || device_reset) begin
            power_state <= 3'h0;
        end else begin
            power_state <= 3'(next_state);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // regulator settling on return to main mode
    always_ff @(posedge clock) begin
        if (sys_rst || device_reset) begin
            settle_count <= 8'h00;
        end else if (regulator_main_mode) begin
            if (settle_count < 8'(settle_cycles)) begin
                settle_count <= settle_count + 8'h01;
            end
        end else begin
            settle_count <= 8'h00;
        end
    end

    assign settled = regulator_main_mode &&
        settle_count >= 8'(settle_cycles);

    always_ff @(posedge clock) begin
        if (sys_rst || device_reset) begin
            regulator_on <= 1'b1;
            regulator_main_mode <= 1'b1;
            regulator_low_power_mode <= 1'b0;
            regulator_high_z <= 1'b0;
            core_power_on <= 1'b1;
        end else if (next_state == pms_pkg::pms_standby) begin
            regulator_on <= 1'b0;
            regulator_main_mode <= 1'b0;
            regulator_low_power_mode <= 1'b0;
            regulator_high_z <= 1'b1;
            core_power_on <= 1'b0;
        end else if (next_state == pms_pkg::pms_stop &&
                stop_low_power_select && rc_clock_request == 3'h0) begin
            regulator_main_mode <= 1'b0;
            regulator_low_power_mode <= 1'b1;
        end else begin
            regulator_main_mode <= 1'b1;
            regulator_low_power_mode <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // clocks and rc grants
    always_ff @(posedge clock) begin
        if (sys_rst || device_reset) begin
            cpu_clock_enable <= 1'b1;
            core_clock_enable <= 1'b1;
            pll_enable <= 1'b0;
            internal_fast_rc_osc_enable <= 1'b1;
            external_crystal_osc_enable <= 1'b0;
            rc_clock_grant <= 3'h0;
        end else begin
            case (next_state)
                pms_pkg::pms_run: begin
                    cpu_clock_enable <= 1'b1;
                    core_clock_enable <= 1'b1;
                    pll_enable <= cpu_clock_source == pms_pkg::pms_clk_pll;
                    internal_fast_rc_osc_enable <= 1'b1;
                    external_crystal_osc_enable <=
                        cpu_clock_source != pms_pkg::pms_clk_rc;
                    rc_clock_grant <= rc_clock_request;
                end
                pms_pkg::pms_sleep: begin
                    cpu_clock_enable <= 1'b0;
                    core_clock_enable <= 1'b1;
                    rc_clock_grant <= rc_clock_request;
                end
                default: begin
                    cpu_clock_enable <= 1'b0;
                    core_clock_enable <= 1'b0;
                    pll_enable <= 1'b0;
                    external_crystal_osc_enable <= 1'b0;
                    internal_fast_rc_osc_enable <= rc_clock_request != 3'h0 &&
                        next_state != pms_pkg::pms_standby;
                    rc_clock_grant <= (settled &&
                        next_state != pms_pkg::pms_standby) ?
                        rc_clock_request : 3'h0;
                end
            endcase
        end
    end

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            always_on_clocks_enable <= 1'b1;
        end else begin
            always_on_clocks_enable <= 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // processor clock source and failure fallback
    always_ff @(posedge clock) begin
        if (sys_rst || device_reset) begin
            cpu_clock_source <= pms_pkg::pms_clk_rc;
            clock_fail_irq <= 1'b0;
        end else if (ext_failed) begin
            cpu_clock_source <= pms_pkg::pms_clk_rc;
            clock_fail_irq <= clock_fail_irq || clock_fail_irq_enable;
        end else if (state == pms_pkg::pms_stop_exit) begin
            cpu_clock_source <= pms_pkg::pms_clk_rc;
        end else if (state == pms_pkg::pms_run) begin
            cpu_clock_source <= clock_select;
        end
    end
endmodule : pms_supervisor

// [pms_supervisor_bench.sv]
/*
 bench for pms_supervisor with far side model.
 assumes 25 MHz clock, sync active-high reset.
*/
`timescale 1ns/1ns
module pms_supervisor_bench;
    logic clock, sys_rst, main_supply_ok, analog_supply_ok;
    logic analog_monitor_disable, detector_above_level, detector_enable;
    logic detector_event_clear, io_rail_ok, sleep_request, stop_request;
    logic standby_request, stop_low_power_select, external_reset_pin_n;
    logic watchdog_reset, wakeup_pin, rtc_event, interrupt_event;
    logic external_clock_activity, clock_fail_irq_enable, osc_run;
    logic [1:0] detector_mode, clock_select, cpu_clock_source;
    logic [15:0] external_lines;
    logic [14:0] peripheral_lines;
    logic [2:0] rc_clock_request, want_rc, rc_clock_grant, power_state;
    logic device_reset, detector_irq, regulator_on, regulator_main_mode;
    logic regulator_low_power_mode, regulator_high_z, core_power_on;
    logic cpu_clock_enable, core_clock_enable, pll_enable, io_rail_enable;
    logic internal_fast_rc_osc_enable, external_crystal_osc_enable;
    logic always_on_clocks_enable, clock_fail_irq;
    logic [31:0] wakeup_lines;
    int mismatches, checked, n;

    pms_supervisor #(.settle_cycles(4), .fail_window(8)) dut (
        .clock, .sys_rst, .main_supply_ok, .analog_supply_ok,
        .analog_monitor_disable, .detector_above_level, .detector_enable,
        .detector_mode, .detector_event_clear, .io_rail_ok, .sleep_request,
        .stop_request, .standby_request, .stop_low_power_select,
        .external_lines, .peripheral_lines, .rc_clock_request,
        .external_reset_pin_n, .watchdog_reset, .wakeup_pin, .rtc_event,
        .interrupt_event, .clock_select, .external_clock_activity,
        .clock_fail_irq_enable, .device_reset, .detector_irq, .regulator_on,
        .regulator_main_mode, .regulator_low_power_mode, .regulator_high_z,
        .core_power_on, .cpu_clock_enable, .core_clock_enable, .pll_enable,
        .internal_fast_rc_osc_enable, .external_crystal_osc_enable,
        .always_on_clocks_enable, .rc_clock_grant, .io_rail_enable,
        .wakeup_lines, .cpu_clock_source, .clock_fail_irq, .power_state
    );
    pms_far_side far (.clock, .osc_run, .want_rc, .rc_clock_grant,
        .rc_clock_request, .external_clock_activity);

    always #20 clock = ~clock;
    ////////////////////////////////////////////////////////////////////////
    task end_sim;
        if (mismatches == 0 && checked > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : end_sim

    task chk(input string name, input logic [31:0] seen, exp);
        checked++;
        if (seen !== exp) begin
            mismatches++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
        end
    endtask : chk

    task cyc(input int k);
        repeat (k) @(posedge clock);
        #1;
    endtask : cyc

    task wait_ps(input logic [2:0] st);
        for (n = 0; n < 300; n++) begin
            cyc(1);
            if (power_state === st && device_reset === 1'b0) return;
        end
        mismatches++;
        end_sim();
    endtask : wait_ps

    task req(input int k);
        @(posedge clock);
        sleep_request <= (k == 0);
        stop_request <= (k == 1);
        standby_request <= (k == 2);
        @(posedge clock);
        {sleep_request, stop_request, standby_request} <= 3'h0;
        cyc(3);
    endtask : req

    task pulse_reset;
        @(posedge clock);
        sys_rst <= 1'b1;
        repeat (12) @(posedge clock);
        sys_rst <= 1'b0;
        wait_ps(3'h0);
        chk("source", cpu_clock_source, 2'h0);
        chk("regulator", {regulator_on, regulator_main_mode}, 2'h3);
    endtask : pulse_reset
    ////////////////////////////////////////////////////////////////////////
    initial begin
        clock = 0;
        {main_supply_ok, analog_supply_ok, io_rail_ok} = 3'h7;
        {detector_above_level, external_reset_pin_n} = 2'h3;
        {analog_monitor_disable, detector_enable, detector_event_clear} = 0;
        {sleep_request, stop_request, standby_request} = 3'h0;
        {stop_low_power_select, watchdog_reset, wakeup_pin} = 3'h0;
        {rtc_event, interrupt_event, clock_fail_irq_enable} = 3'h0;
        {osc_run, detector_mode, clock_select, want_rc} = 0;
        {external_lines, peripheral_lines} = 0;
        mismatches = 0;
        checked = 0;
        sys_rst = 1'b1;
        pulse_reset();
        main_supply_ok <= 1'b0;
        cyc(8);
        chk("low supply reset", device_reset, 1'b1);
        main_supply_ok <= 1'b1;
        analog_supply_ok <= 1'b0;
        cyc(8);
        chk("analog reset", device_reset, 1'b1);
        analog_monitor_disable <= 1'b1;
        wait_ps(3'h0);
        detector_mode <= 2'h1;
        detector_above_level <= 1'b0;
        cyc(8);
        chk("detector off", detector_irq, 1'b0);
        detector_above_level <= 1'b1;
        detector_enable <= 1'b1;
        cyc(8);
        detector_above_level <= 1'b0;
        cyc(8);
        chk("fall irq", {detector_irq, wakeup_lines[16]}, 2'h3);
        detector_event_clear <= 1'b1;
        detector_mode <= 2'h2;
        cyc(1);
        detector_event_clear <= 1'b0;
        cyc(2);
        chk("irq cleared", detector_irq, 1'b0);
        detector_above_level <= 1'b1;
        cyc(8);
        chk("rise irq", detector_irq, 1'b1);
        // io rail
        io_rail_ok <= 1'b0;
        cyc(8);
        chk("io off", {io_rail_enable, wakeup_lines[31]}, 2'h1);
        io_rail_ok <= 1'b1;
        cyc(8);
        chk("io on", io_rail_enable, 1'b1);
        // sleep, refused stop inside sleep, wake on interrupt
        req(0);
        chk("sleep", {power_state, cpu_clock_enable}, 4'h2);
        req(1);
        chk("sleep kept", power_state, 3'h1);
        interrupt_event <= 1'b1;
        wait_ps(3'h0);
        interrupt_event <= 1'b0;
        // external clock, then low-power stop with rc grant
        osc_run <= 1'b1;
        clock_select <= 2'h1;
        cyc(10);
        chk("ext source", cpu_clock_source, 2'h1);
        stop_low_power_select <= 1'b1;
        req(1);
        chk("stop", power_state, 3'h3);
        chk("stop clocks", {core_clock_enable, pll_enable,
            internal_fast_rc_osc_enable, external_crystal_osc_enable}, 0);
        chk("lp mode", regulator_low_power_mode, 1'b1);
        want_rc <= 3'h2;
        for (n = 0; n < 100 && rc_clock_grant[1] !== 1'b1; n++) cyc(1);
        chk("grant main", {rc_clock_grant[1], regulator_main_mode}, 2'h3);
        want_rc <= 3'h0;
        cyc(4);
        external_lines <= 16'h0020;
        wait_ps(3'h0);
        external_lines <= 16'h0000;
        // standby, left by each documented source
        for (int k = 0; k < 4; k++) begin
            req(2);
            chk("standby", {regulator_high_z, core_power_on}, 2'h2);
            chk("aon", always_on_clocks_enable, 1'b1);
            external_reset_pin_n <= (k != 0);
            watchdog_reset <= (k == 1);
            wakeup_pin <= (k == 2);
            rtc_event <= (k == 3);
            cyc(6);
            {watchdog_reset, wakeup_pin, rtc_event} <= 3'h0;
            external_reset_pin_n <= 1'b1;
            wait_ps(3'h0);
        end
        // clock failure, interrupt masked then enabled
        clock_select <= 2'h1;
        cyc(10);
        osc_run <= 1'b0;
        cyc(20);
        chk("fallback", {cpu_clock_source, clock_fail_irq}, 3'h0);
        pulse_reset();
        clock_fail_irq_enable <= 1'b1;
        osc_run <= 1'b1;
        cyc(10);
        osc_run <= 1'b0;
        for (n = 0; n < 50 && clock_fail_irq !== 1'b1; n++) cyc(1);
        cyc(2);
        chk("fail irq", {cpu_clock_source, clock_fail_irq}, 3'h1);
        end_sim();
    end
endmodule : pms_supervisor_bench

// [pms_supervisor_properties.sv]
/*
 checker for pms_supervisor: port-level relations over time.
 assumes one clock and the synchronous active-high reset sys_rst.
*/
`timescale 1ns/1ns
module pms_supervisor_properties #(
    parameter int settle_cycles = 4,
    parameter int fail_window = 8
) (
    input wire logic clock,
    input wire logic sys_rst,
    input wire logic main_supply_ok,
    input wire logic io_rail_ok,
    input wire logic detector_enable,
    input wire logic clock_fail_irq_enable,
    input wire logic sleep_request,
    input wire logic stop_request,
    input wire logic standby_request,
    input wire logic device_reset,
    input wire logic detector_irq,
    input wire logic regulator_on,
    input wire logic regulator_main_mode,
    input wire logic regulator_high_z,
    input wire logic core_power_on,
    input wire logic cpu_clock_enable,
    input wire logic core_clock_enable,
    input wire logic pll_enable,
    input wire logic external_crystal_osc_enable,
    input wire logic always_on_clocks_enable,
    input wire logic [2:0] rc_clock_grant,
    input wire logic io_rail_enable,
    input wire logic [31:0] wakeup_lines,
    input wire logic [1:0] cpu_clock_source,
    input wire logic clock_fail_irq,
    input wire logic [2:0] power_state
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (sys_rst);
    ////////////////////////////////////////////////////////////////////////
    a_reset_rc_main:
        assert property ($fell(sys_rst) |-> cpu_clock_source == 2'h0
            && regulator_on && regulator_main_mode)
        else $error("clock or regulator wrong after reset");
    a_low_supply_reset:
        assert property (!main_supply_ok [*7] |-> device_reset)
        else $error("no reset on low supply");
    a_standby_off:
        assert property (power_state == 3'h5 && $past(power_state) == 3'h5
            |-> regulator_high_z && !core_power_on && !regulator_on)
        else $error("core powered in standby");
    a_sleep_cpu_only:
        assert property (power_state == 3'h1 && $past(power_state) == 3'h1
            |-> !cpu_clock_enable && core_clock_enable)
        else $error("sleep clocks wrong");
    a_stop_clocks_off:
        assert property (power_state == 3'h3 && $past(power_state) == 3'h3
            |-> !core_clock_enable && !pll_enable
            && !external_crystal_osc_enable && always_on_clocks_enable)
        else $error("stop clocks wrong");
    a_entry_by_request:
        assert property ($past(power_state) == 3'h0
            && power_state inside {3'h1, 3'h2, 3'h5}
            |-> $past(sleep_request || stop_request || standby_request))
        else $error("low power mode without request");
    a_grant_main_mode:
        assert property (|rc_clock_grant |-> regulator_main_mode)
        else $error("rc grant in low power regulator mode");
    a_io_rail_off:
        assert property (!io_rail_ok [*7]
            |-> !io_rail_enable && wakeup_lines[31])
        else $error("io rail low not handled");
    a_detector_idle:
        assert property (!detector_enable [*8] |-> !$rose(detector_irq))
        else $error("detector irq while disabled");
    a_fail_fallback:
        assert property ($rose(clock_fail_irq) |-> $past(clock_fail_irq_enable)
            ##[0:2] cpu_clock_source == 2'h0)
        else $error("clock failure handling wrong");
    a_stop_wake_rc:
        assert property ($past(power_state) == 3'h4 && power_state == 3'h0
            |-> ##[0:1] cpu_clock_source == 2'h0)
        else $error("wake from stop not on rc");
    ////////////////////////////////////////////////////////////////////////
    c_stop_exit: cover property (power_state == 3'h3 ##1 power_state == 3'h4);
    c_clock_fail: cover property ($rose(clock_fail_irq));
    c_rc_grant: cover property ($rose(|rc_clock_grant));
endmodule : pms_supervisor_properties

bind pms_supervisor pms_supervisor_properties #(
    .settle_cycles(settle_cycles),
    .fail_window(fail_window)
) u_props (.*);

// [pms_sync.sv]
/*
 three-flop synchroniser with agreement filter.
 assumes asynchronous input, one clock, synchronous active-high reset.
*/
`timescale 1ns/1ns
module pms_sync #(
    parameter int width = 1
) (
    input wire logic clock,
    input wire logic sys_rst,
    input wire logic [width-1:0] async_in,
    output logic [width-1:0] sync_out
);
    logic [width-1:0] stage1;
    logic [width-1:0] stage2;
    logic [width-1:0] stage3;

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            stage1 <= '0;
            stage2 <= '0;
            stage3 <= '0;
        end else begin
            stage1 <= async_in;
            stage2 <= stage1;
            stage3 <= stage2;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    genvar i;
    generate
        for (i = 0; i < width; i++) begin : g_bit
            always_ff @(posedge clock) begin
                if (sys_rst) begin
                    sync_out[i] <= 1'b0;
                end else if (stage2[i] == stage3[i]) begin
                    sync_out[i] <= stage3[i];
                end
            end
        end
    endgenerate
endmodule : pms_sync
